/* dv/rcts_regs_sva.sv */
// Checker of the radio timebase and sleep register slice.
// Bound to rcts_regs from the testbench top file.
`timescale 1ns/1ps
`default_nettype none

module rcts_regs_sva (
    // Clock and reset
    input wire logic                    sys_clk,
    input wire logic                    resetn,
    // Bus and status
    input wire rcts_pkg::rcts_axi_req_s s_axi_req,
    input wire rcts_pkg::rcts_axi_rsp_s s_axi_rsp,
    input wire logic                    deep_sleep_active,
    input wire logic                    low_power_wake_interrupt
);
    import rcts_pkg::*;

    localparam logic [31:0] HOLE_OFS = 32'h40000040;

    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!resetn);

    // ****************************************
    // Sequences and assertions
    // ****************************************
    sequence wr_taken;
        s_axi_req.awvalid && s_axi_rsp.awready && s_axi_req.wvalid && s_axi_rsp.wready;
    endsequence
    sequence sleep_wr;
        wr_taken ##0 (s_axi_req.awaddr == SLEEP_CTL_OFS && s_axi_req.wstrb[0]
            && s_axi_req.wdata[SLEEP_ON_BIT] && !deep_sleep_active);
    endsequence

    a_read_latency: assert property (s_axi_req.arvalid && s_axi_rsp.arready |=> s_axi_rsp.rvalid)
        else $error("read answer late");
    a_read_hold: assert property (s_axi_rsp.rvalid && !s_axi_req.rready |=> s_axi_rsp.rvalid
        && $stable(s_axi_rsp.rdata)) else $error("read answer dropped");
    a_no_read_overlap: assert property (s_axi_rsp.rvalid |-> !s_axi_rsp.arready)
        else $error("read taken while answer pending");
    a_write_latency: assert property (wr_taken |=> !s_axi_rsp.bvalid ##1 s_axi_rsp.bvalid)
        else $error("write answer timing");
    a_write_release: assert property (s_axi_rsp.bvalid && s_axi_req.bready |=> !s_axi_rsp.bvalid)
        else $error("write answer not released");
    a_hole_read: assert property (
        s_axi_req.arvalid && s_axi_rsp.arready && s_axi_req.araddr == HOLE_OFS
        |=> s_axi_rsp.rresp == RESP_SLVERR && s_axi_rsp.rdata == 32'h0)
        else $error("unmapped read answer");
    a_sleep_entry: assert property (sleep_wr |-> ##[2:4] deep_sleep_active)
        else $error("sleep request not honoured");
    a_wake_irq_cause: assert property ($rose(low_power_wake_interrupt) |->
        !deep_sleep_active && ($past(deep_sleep_active) || $past(deep_sleep_active, 2)))
        else $error("wake interrupt without wake");
endmodule : rcts_regs_sva

`default_nettype wire

/* dv/rcts_regs_tb.sv */
// Testbench of the radio timebase and sleep register slice.
// Assumes rcts_pkg, rcts_regs and rcts_regs_sva compiled before it.
`timescale 1ns/1ps
`default_nettype none

module rcts_regs_tb;
    import rcts_pkg::*;

    // ****************************************
    // Signals and tables
    // ****************************************
    logic          sys_clk    = 1'b0;
    logic          resetn     = 1'b0;
    rcts_axi_req_s req        = '0;
    rcts_axi_rsp_s rsp;
    logic          lp_clk     = 1'b0;
    logic          ext_wake   = 1'b0;
    logic [26:0]   slot_corr  = '0;
    logic [9:0]    us_corr    = '0;
    logic          asleep;
    logic          lpwi;
    logic          irq;
    logic [31:0]   rd_v;
    logic [1:0]    resp;
    int            errors     = 0;
    int            n_compared = 0;
    int            cycles     = 0;
    localparam logic [31:0] OFS [7] = '{BASE_SNAP_OFS, FINE_SNAP_OFS, ADDR_LO_OFS,
        ADDR_HI_OFS, PTRS_OFS, SLEEP_CTL_OFS, EVT_STAT_OFS};
    localparam logic [31:0] ROWS [9][4] = '{
        '{ADDR_LO_OFS,   32'hFFFFFFFF, 32'hFFFFFFFF, 32'h0},
        '{ADDR_HI_OFS,   32'hFFFFFFFF, 32'h0001FFFF, 32'h0},
        '{ADDR_HI_OFS,   32'h0000A5C3, 32'h0000A5C3, 32'h0},
        '{PTRS_OFS,      32'hFFFFFFFF, 32'hFFFF7FFF, 32'h0},
        '{PTRS_OFS,      32'h12345678, 32'h12345678, 32'h0},
        '{BASE_SNAP_OFS, 32'hFFFFFFFF, 32'h00000000, 32'h0},
        '{SLEEP_LEN_OFS, 32'hA5A5F00F, 32'hA5A5F00F, 32'h0},
        '{EVT_EN_OFS,    32'hFFFFFFFF, 32'h00000003, 32'h0},
        '{32'h40000040,  32'hFFFFFFFF, 32'h00000000, 32'h2}};

    always #(CLK_PERIOD_NS / 2) sys_clk = ~sys_clk;

    rcts_regs u_dut (
        .sys_clk                  (sys_clk),
        .resetn                   (resetn),
        .s_axi_req                (req),
        .s_axi_rsp                (rsp),
        .lp_clk                   (lp_clk),
        .ext_wake_req             (ext_wake),
        .slot_counter_corr        (slot_corr),
        .microsecond_counter_corr (us_corr),
        .deep_sleep_active        (asleep),
        .low_power_wake_interrupt (lpwi),
        .irq                      (irq)
    );

    // ****************************************
    // Tasks
    // ****************************************
    task automatic stop_test;
        if (errors == 0 && n_compared > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask : stop_test

    task automatic chk(input logic [31:0] got, input logic [31:0] lo, input logic [31:0] hi);
        n_compared++;
        if (((got >= lo) && (got <= hi)) !== 1'b1) begin
            errors++;
            $display("ERROR %0t got %h want %h", $time, got, lo);
        end
    endtask : chk

    task automatic wr(input logic [31:0] a, input logic [31:0] d);
        logic aw;
        logic w;
        aw = 1'b1;
        w  = 1'b1;
        @(posedge sys_clk);
        req.awaddr  <= a;
        req.wdata   <= d;
        req.wstrb   <= 4'hF;
        req.awvalid <= 1'b1;
        req.wvalid  <= 1'b1;
        req.bready  <= 1'b1;
        while (aw || w) begin
            @(posedge sys_clk);
            aw = aw && (rsp.awready !== 1'b1);
            w  = w && (rsp.wready !== 1'b1);
            req.awvalid <= aw;
            req.wvalid  <= w;
        end
        do @(posedge sys_clk); while (rsp.bvalid !== 1'b1);
        resp = rsp.bresp;
        req.bready <= 1'b0;
    endtask : wr

    task automatic rd(input logic [31:0] a);
        @(posedge sys_clk);
        req.araddr  <= a;
        req.arvalid <= 1'b1;
        req.rready  <= 1'b1;
        do @(posedge sys_clk); while (rsp.arready !== 1'b1);
        req.arvalid <= 1'b0;
        do @(posedge sys_clk); while (rsp.rvalid !== 1'b1);
        rd_v = rsp.rdata;
        resp = rsp.rresp;
        req.rready <= 1'b0;
    endtask : rd

    task automatic nap(input logic [31:0] len, input logic [31:0] ctl);
        wr(SLEEP_LEN_OFS, len);
        wr(SLEEP_CTL_OFS, ctl | 32'(IRQ_EN_ALL));
        repeat (2) @(negedge sys_clk);
    endtask : nap

    task automatic lp(input int n);
        repeat (n) begin
            lp_clk <= 1'b1;
            repeat (3) @(posedge sys_clk);
            lp_clk <= 1'b0;
            repeat (3) @(posedge sys_clk);
        end
    endtask : lp

    task automatic wake;
        for (int t = 0; t < 40 && asleep !== 1'b0; t++) @(posedge sys_clk);
        @(negedge sys_clk);
    endtask : wake

    // ****************************************
    // Watchdog and main sequence
    // ****************************************
    always @(posedge sys_clk) begin
        cycles <= cycles + 1;
        if (cycles == 5000) begin
            errors++;
            stop_test();
        end
    end

    initial begin
        repeat (12) @(posedge sys_clk);
        resetn <= 1'b1;
        foreach (OFS[i]) begin
            rd(OFS[i]);
            chk(rd_v, 32'h0, 32'h0);
        end
        for (int i = 0; i < 9; i++) begin
            wr(ROWS[i][0], ROWS[i][1]);
            chk(32'(resp), ROWS[i][3], ROWS[i][3]);
            rd(ROWS[i][0]);
            chk(rd_v, ROWS[i][2], ROWS[i][2]);
            chk(32'(resp), ROWS[i][3], ROWS[i][3]);
        end
        wr(EVT_EN_OFS, 32'h0);
        nap(32'hFFFF, 32'h4);
        wr(SLEEP_CTL_OFS, 32'h10);
        wake();
        chk(32'(asleep), 32'h0, 32'h0);
        chk(32'(lpwi), 32'h0, 32'h0);
        rd(EVT_STAT_OFS);
        chk(rd_v, 32'h3, 32'h3);
        chk(32'(irq), 32'h0, 32'h0);
        wr(EVT_EN_OFS, 32'h3);
        @(negedge sys_clk);
        chk(32'(irq), 32'h1, 32'h1);
        wr(EVT_CLR_OFS, 32'h3);
        @(negedge sys_clk);
        chk(32'(irq), 32'h0, 32'h0);
        ext_wake <= 1'b1;
        nap(32'h3, 32'h80000007);
        chk(32'(asleep), 32'h1, 32'h1);
        rd(SLEEP_CTL_OFS);
        chk(rd_v & 32'hFFFFFFFB, 32'h80008003, 32'h80008003);
        lp(2);
        chk(32'(asleep), 32'h1, 32'h1);
        lp(1);
        wake();
        chk(32'(asleep), 32'h0, 32'h0);
        chk(32'(lpwi), 32'h1, 32'h1);
        rd(SLEEP_CTL_OFS);
        chk(rd_v, 32'h80000003, 32'h80000003);
        ext_wake <= 1'b0;
        nap(32'hFFFF, 32'h7);
        ext_wake <= 1'b1;
        wake();
        chk(32'(asleep), 32'h0, 32'h0);
        ext_wake <= 1'b0;
        nap(32'hFFFF, 32'h7);
        wr(SLEEP_CTL_OFS, 32'h13);
        wake();
        chk(32'(asleep), 32'h0, 32'h0);
        wr(SLEEP_CTL_OFS, 32'h13);
        repeat (3) @(negedge sys_clk);
        chk(32'(asleep), 32'h0, 32'h0);
        rd(SLEEP_CTL_OFS);
        chk(rd_v, 32'h3, 32'h3);
        slot_corr <= 27'h5;
        us_corr   <= 10'h26F;
        wr(SLEEP_CTL_OFS, 32'hB);
        @(negedge sys_clk);
        chk(32'(lpwi), 32'h0, 32'h0);
        rd(SLEEP_CTL_OFS);
        chk(rd_v, 32'h3, 32'h3);
        repeat (600) @(posedge sys_clk);
        wr(SAMPLE_OFS, 32'h1);
        rd(BASE_SNAP_OFS);
        chk(rd_v, 32'h6, 32'h6);
        rd(FINE_SNAP_OFS);
        chk(rd_v, 32'h0, 32'h1);
        resetn <= 1'b0;
        repeat (2) @(posedge sys_clk);
        resetn <= 1'b1;
        rd(ADDR_LO_OFS);
        chk(rd_v, 32'h0, 32'h0);
        rd(SLEEP_CTL_OFS);
        chk(rd_v, 32'h0, 32'h0);
        stop_test();
    end
endmodule : rcts_regs_tb

bind rcts_regs rcts_regs_sva u_sva (.sys_clk(sys_clk), .resetn(resetn), .s_axi_req(s_axi_req),
    .s_axi_rsp(s_axi_rsp), .deep_sleep_active(deep_sleep_active),
    .low_power_wake_interrupt(low_power_wake_interrupt));

`default_nettype wire

/* rtl/rcts_pkg.sv */
// Constants and carriers of the radio timebase and sleep register slice.
// Assumes a 250 MHz system clock and a 32-bit AXI4-Lite master.
package rcts_pkg;

    // ****************************************
    // Register byte addresses
    // ****************************************
    localparam logic [31:0] BASE_SNAP_OFS = 32'h4000001C;
    localparam logic [31:0] FINE_SNAP_OFS = 32'h40000020;
    localparam logic [31:0] ADDR_LO_OFS   = 32'h40000024;
    localparam logic [31:0] ADDR_HI_OFS   = 32'h40000028;
    localparam logic [31:0] PTRS_OFS      = 32'h4000002C;
    localparam logic [31:0] SLEEP_CTL_OFS = 32'h40000030;
    localparam logic [31:0] SLEEP_LEN_OFS = 32'h40000060;
    localparam logic [31:0] EVT_STAT_OFS  = 32'h40000064;
    localparam logic [31:0] EVT_CLR_OFS   = 32'h40000068;
    localparam logic [31:0] EVT_EN_OFS    = 32'h4000006C;
    localparam logic [31:0] SAMPLE_OFS    = 32'h40000070;

    // ****************************************
    // Field positions
    // ****************************************
    localparam int PRIV_BIT       = 16;
    localparam int ETS_LSB        = 16;
    localparam int EXT_BLOCK_BIT  = 31;
    localparam int SLEEP_STAT_BIT = 15;
    localparam int SW_WAKE_BIT    = 4;
    localparam int CORR_GO_BIT    = 3;
    localparam int SLEEP_ON_BIT   = 2;
    localparam int SAMPLE_BIT     = 0;
    localparam int EVT_WAKE_BIT   = 0;
    localparam int EVT_SLEEP_BIT  = 1;

    // ****************************************
    // Reset values and answers
    // ****************************************
    localparam logic [31:0] RESET_WORD  = 32'h0000_0000;
    localparam logic [1:0]  RESP_OKAY   = 2'h0;
    localparam logic [1:0]  RESP_SLVERR = 2'h2;
    localparam logic [1:0]  IRQ_EN_ALL  = 2'h3;

    // ****************************************
    // Timing
    // ****************************************
    localparam int CLK_PERIOD_NS = 4;
    localparam int US_NS         = 1000;
    localparam int SLOT_US       = 625;
    localparam int CYC_PER_US    = US_NS / CLK_PERIOD_NS;
    localparam logic [7:0] US_DIV_LAST = 8'(CYC_PER_US - 1);
    localparam logic [9:0] FINE_LAST   = 10'(SLOT_US - 1);

    // ****************************************
    // Bus carriers
    // ****************************************
    typedef struct packed {
        logic [31:0] awaddr;
        logic        awvalid;
        logic [31:0] wdata;
        logic [3:0]  wstrb;
        logic        wvalid;
        logic        bready;
        logic [31:0] araddr;
        logic        arvalid;
        logic        rready;
    } rcts_axi_req_s;

    typedef struct packed {
        logic        awready;
        logic        wready;
        logic [1:0]  bresp;
        logic        bvalid;
        logic        arready;
        logic [31:0] rdata;
        logic [1:0]  rresp;
        logic        rvalid;
    } rcts_axi_rsp_s;

endpackage : rcts_pkg

/* rtl/rcts_regs.sv */
// Timebase snapshots, link address, buffer pointers and deep-sleep control.
// Assumes an AXI4-Lite master, a low power clock sampled on sys_clk.
//
// What this block does
// RULE1: 27-bit base time copy, refreshed on each sample strobe write.
// RULE2: 10-bit microsecond counter copy, refreshed on each sample strobe write.
// RULE3: Lower 32 address bits in a read-write register, reset zero.
// RULE4: Upper 16 address bits in low half of second register, reset zero.
// RULE5: Bit 16 of upper register marks address private when one.
// RULE6: 16-bit read-write exchange table start pointer.
// RULE7: 15-bit read-write receive descriptor list start pointer.
// RULE8: Block bit set makes external wake requests ignored.
// RULE9: Read-only status bit shows deep sleep is in force.
// RULE10: Software wake bit wakes from deep sleep, then self-clears; zero ignored.
// RULE11: Correction go restarts counters with corrections after wake; self-clears.
// RULE12: Sleep request enters deep sleep; cleared on status falling edge.
// RULE13: Software writes wake interrupt enable three whenever requesting sleep.
// RULE14: Two-bit enable field gates the low power wake interrupt.
// RULE15: Sleep lasts the programmed number of low power clock cycles.
// RULE16: Undefined bits read zero and ignore writes.
//
// Decided for this implementation: register access over AXI4-Lite.
`timescale 1ns/1ps
`default_nettype none

module rcts_regs (
    // Clock and reset
    input  wire logic                   sys_clk,
    input  wire logic                   resetn,
    // Register bus
    input  wire rcts_pkg::rcts_axi_req_s s_axi_req,
    output rcts_pkg::rcts_axi_rsp_s     s_axi_rsp,
    // Sleep environment
    input  wire logic                   lp_clk,
    input  wire logic                   ext_wake_req,
    input  wire logic [26:0]            slot_counter_corr,
    input  wire logic [9:0]             microsecond_counter_corr,
    // Status and interrupts
    output logic                        deep_sleep_active,
    output logic                        low_power_wake_interrupt,
    output logic                        irq
);
    import rcts_pkg::*;

    // ****************************************
    // State
    // ****************************************
    typedef struct packed {
        logic        aw_held;
        logic [31:0] awaddr;
        logic        w_held;
        logic [31:0] wdata;
        logic [3:0]  wstrb;
        logic        bvalid;
        logic [1:0]  bresp;
        logic        rvalid;
        logic [31:0] rdata;
        logic [1:0]  rresp;
        logic [26:0] slot_counter_value;
        logic [9:0]  microsecond_counter_value;
        logic [7:0]  us_div;
        logic        cnt_run;
        logic [26:0] base_snap;
        logic [9:0]  fine_snap;
        logic [31:0] link_address_lower;
        logic [15:0] link_address_upper;
        logic        address_is_private;
        logic [15:0] exchange_table_start;
        logic [14:0] receive_list_start;
        logic        external_wake_block;
        logic        sleep_on;
        logic        asleep;
        logic        software_wake_request;
        logic [1:0]  wake_irq_en;
        logic [31:0] sleep_length_cycles;
        logic [31:0] sleep_cnt;
        logic        lp_prev;
        logic [1:0]  evt_stat;
        logic [1:0]  evt_en;
        logic        wake_irq;
    } rcts_state_s;

    rcts_state_s st_r;
    rcts_state_s st_nxt;

    logic        wr_go;
    logic        wr_hit;
    logic        rd_hit;
    logic [31:0] rd_word;
    logic [31:0] wmask;
    logic [31:0] wv;
    logic [1:0]  evt_set;
    logic        lp_rise;
    logic        wake_now;
    logic        timer_done;

    // ****************************************
    // Byte lane mask
    // ****************************************
    genvar gi;
    generate
        for (gi = 0; gi < 4; gi++) begin : g_lane
            assign wmask[gi*8 +: 8] = {8{st_r.wstrb[gi]}};
        end
    endgenerate

    // ****************************************
    // Read decode
    // ****************************************
    always_comb begin
        rd_hit  = 1'b1;
        rd_word = RESET_WORD;
        unique case (s_axi_req.araddr)
            BASE_SNAP_OFS: rd_word = {5'h00, st_r.base_snap}; // RULE1 RULE16
            FINE_SNAP_OFS: rd_word = {22'h000000, st_r.fine_snap}; // RULE2
            ADDR_LO_OFS:   rd_word = st_r.link_address_lower; // RULE3
            ADDR_HI_OFS:   rd_word = {15'h0000, st_r.address_is_private,
                                      st_r.link_address_upper}; // RULE4 RULE5
            PTRS_OFS:      rd_word = {st_r.exchange_table_start, 1'b0,
                                      st_r.receive_list_start}; // RULE6 RULE7
            SLEEP_CTL_OFS: rd_word = {st_r.external_wake_block, 15'h0000,
                                      st_r.asleep, 10'h000,
                                      st_r.software_wake_request, 1'b0,
                                      st_r.sleep_on, st_r.wake_irq_en}; // RULE9
            SLEEP_LEN_OFS: rd_word = st_r.sleep_length_cycles;
            EVT_STAT_OFS:  rd_word = {30'h00000000, st_r.evt_stat};
            EVT_EN_OFS:    rd_word = {30'h00000000, st_r.evt_en};
            EVT_CLR_OFS:   rd_word = RESET_WORD;
            SAMPLE_OFS:    rd_word = RESET_WORD;
            default:       rd_hit  = 1'b0;
        endcase
    end

    // ****************************************
    // Next state
    // ****************************************
    always_comb begin
        st_nxt     = st_r;
        evt_set    = 2'h0;
        wr_hit     = 1'b0;
        wv         = (st_r.wdata & wmask);
        wr_go      = st_r.aw_held && st_r.w_held && !st_r.bvalid;
        lp_rise    = lp_clk && !st_r.lp_prev;
        timer_done = st_r.sleep_cnt >= st_r.sleep_length_cycles;
        wake_now   = 1'b0;
        st_nxt.lp_prev = lp_clk;

        // Write channel capture
        if (s_axi_rsp.awready && s_axi_req.awvalid) begin
            st_nxt.aw_held = 1'b1;
            st_nxt.awaddr  = s_axi_req.awaddr;
        end
        if (s_axi_rsp.wready && s_axi_req.wvalid) begin
            st_nxt.w_held = 1'b1;
            st_nxt.wdata  = s_axi_req.wdata;
            st_nxt.wstrb  = s_axi_req.wstrb;
        end
        if (st_r.bvalid && s_axi_req.bready) begin
            st_nxt.bvalid = 1'b0;
        end

        // Read channel
        if (st_r.rvalid && s_axi_req.rready) begin
            st_nxt.rvalid = 1'b0;
        end
        if (s_axi_rsp.arready && s_axi_req.arvalid) begin
            st_nxt.rvalid = 1'b1;
            st_nxt.rdata  = rd_word;
            st_nxt.rresp  = rd_hit ? RESP_OKAY : RESP_SLVERR;
        end

        // Microsecond and slot counters, stopped from sleep entry until correction go
        if (st_r.cnt_run) begin
            if (st_r.us_div == US_DIV_LAST) begin
                st_nxt.us_div = 8'h00;
                if (st_r.microsecond_counter_value == FINE_LAST) begin
                    st_nxt.microsecond_counter_value = 10'h000;
                    st_nxt.slot_counter_value = st_r.slot_counter_value + 27'h0000001;
                end else begin
                    st_nxt.microsecond_counter_value =
                        st_r.microsecond_counter_value + 10'h001;
                end
            end else begin
                st_nxt.us_div = st_r.us_div + 8'h01;
            end
        end

        // Deep sleep sequencing
        if (st_r.asleep) begin
            if (lp_rise && !timer_done) begin
                st_nxt.sleep_cnt = st_r.sleep_cnt + 32'h00000001; // RULE15
            end
            wake_now = timer_done // RULE15
                || st_r.software_wake_request // RULE10
                || (ext_wake_req && !st_r.external_wake_block); // RULE8
            if (wake_now) begin
                st_nxt.asleep                = 1'b0;
                st_nxt.sleep_on              = 1'b0; // RULE12
                st_nxt.software_wake_request = 1'b0; // RULE10
                evt_set[EVT_WAKE_BIT]        = 1'b1;
                st_nxt.wake_irq = |st_r.wake_irq_en; // RULE14
            end
        end else if (st_r.sleep_on) begin
            st_nxt.asleep    = 1'b1; // RULE12
            st_nxt.cnt_run   = 1'b0;
            st_nxt.sleep_cnt = RESET_WORD;
            evt_set[EVT_SLEEP_BIT] = 1'b1;
        end

        // Register writes
        if (wr_go) begin
            st_nxt.aw_held = 1'b0;
            st_nxt.w_held  = 1'b0;
            st_nxt.bvalid  = 1'b1;
            wr_hit         = 1'b1;
            unique case (st_r.awaddr)
                ADDR_LO_OFS: begin
                    st_nxt.link_address_lower =
                        (st_r.link_address_lower & ~wmask) | wv; // RULE3
                end
                ADDR_HI_OFS: begin
                    if (st_r.wstrb[0]) st_nxt.link_address_upper[7:0] = wv[7:0]; // RULE4
                    if (st_r.wstrb[1]) st_nxt.link_address_upper[15:8] = wv[15:8];
                    if (st_r.wstrb[2]) st_nxt.address_is_private = wv[PRIV_BIT]; // RULE5
                end
                PTRS_OFS: begin
                    if (st_r.wstrb[0]) st_nxt.receive_list_start[7:0] = wv[7:0]; // RULE7
                    if (st_r.wstrb[1]) st_nxt.receive_list_start[14:8] = wv[14:8];
                    if (st_r.wstrb[2]) st_nxt.exchange_table_start[7:0] =
                        wv[ETS_LSB +: 8]; // RULE6
                    if (st_r.wstrb[3]) st_nxt.exchange_table_start[15:8] = wv[31:24];
                end
                SLEEP_CTL_OFS: begin
                    if (st_r.wstrb[3]) begin
                        st_nxt.external_wake_block = wv[EXT_BLOCK_BIT]; // RULE8
                    end
                    if (st_r.wstrb[0]) begin
                        st_nxt.wake_irq_en = wv[1:0]; // RULE14
                        if (wv[SLEEP_ON_BIT]) st_nxt.sleep_on = 1'b1; // RULE12
                        if (wv[SW_WAKE_BIT] && st_r.asleep && !wake_now) begin
                            st_nxt.software_wake_request = 1'b1; // RULE10
                        end
                        if (wv[CORR_GO_BIT] && !st_r.asleep && !st_r.cnt_run) begin
                            st_nxt.cnt_run = 1'b1; // RULE11
                            st_nxt.us_div  = 8'h00;
                            st_nxt.slot_counter_value = slot_counter_corr;
                            st_nxt.microsecond_counter_value = microsecond_counter_corr;
                            st_nxt.wake_irq = 1'b0;
                        end
                    end
                end
                SLEEP_LEN_OFS: begin
                    st_nxt.sleep_length_cycles =
                        (st_r.sleep_length_cycles & ~wmask) | wv; // RULE15
                end
                EVT_CLR_OFS: st_nxt.evt_stat = st_r.evt_stat & ~wv[1:0];
                EVT_EN_OFS:  if (st_r.wstrb[0]) st_nxt.evt_en = wv[1:0];
                SAMPLE_OFS: begin
                    if (wv[SAMPLE_BIT]) begin
                        st_nxt.base_snap = st_r.slot_counter_value; // RULE1
                        st_nxt.fine_snap = st_r.microsecond_counter_value; // RULE2
                    end
                end
                BASE_SNAP_OFS, FINE_SNAP_OFS, EVT_STAT_OFS: wr_hit = 1'b1;
                default: wr_hit = 1'b0; // RULE16
            endcase
            st_nxt.bresp = wr_hit ? RESP_OKAY : RESP_SLVERR;
        end

        // Event flags: a set in the clearing cycle wins
        st_nxt.evt_stat = st_nxt.evt_stat | evt_set;
    end

    // ****************************************
    // Registers
    // ****************************************
    always_ff @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            st_r         <= '0;
            st_r.cnt_run <= 1'b1;
        end else begin
            st_r <= st_nxt;
        end
    end

    // ****************************************
    // Outputs
    // ****************************************
    always_comb begin
        s_axi_rsp.awready = !st_r.aw_held && !st_r.bvalid;
        s_axi_rsp.wready  = !st_r.w_held && !st_r.bvalid;
        s_axi_rsp.bresp   = st_r.bresp;
        s_axi_rsp.bvalid  = st_r.bvalid;
        s_axi_rsp.arready = !st_r.rvalid;
        s_axi_rsp.rdata   = st_r.rdata;
        s_axi_rsp.rresp   = st_r.rresp;
        s_axi_rsp.rvalid  = st_r.rvalid;
    end

    assign deep_sleep_active        = st_r.asleep; // RULE9
    assign low_power_wake_interrupt = st_r.wake_irq; // RULE14
    assign irq                      = |(st_r.evt_stat & st_r.evt_en);

endmodule : rcts_regs

`default_nettype wire
